// [logic/sbe_device.sv]
`timescale 1ns/1ps
// How it works
// R1: master command carries odd parity
// R2: slave checks incoming command parity
// R3: command parity error: ignore, cause, exception
// R4: master address/data carries check code
// R5: check code only when command bit0
// R6: single-bit error corrected, correctable pulse
// R7: address uncorrectable: ignore, cause, exception
// R8: bad read data flags buffer entry
// R9: flagged block forward: one cache exception
// R10: flagged word forward: bus exception
// R11: state bus carries odd parity
// R12: response parity checked on valid
// R13: response parity error: ignore, cause, exception
// R14: agent may soft reset, read cause; no soft reset here, only reset_i clears cause
// R15: odd-column SEC-DED code over 64 bits
module sbe_device (
	input  wire logic        core_clk_i,   // System clock
	input  wire logic        reset_i,      // Sync reset, high
	sbe_if.device            bus,          // System interface
	input  wire logic        master_i,     // Device owns bus
	input  wire logic        tx_valid_i,   // Send a cycle
	input  wire logic [11:0] tx_cmd_i,     // Command to send
	input  wire logic [63:0] tx_ad_i,      // Addr/data to send
	input  wire logic [2:0]  state_i,      // State to drive
	input  wire logic        rd_pending_i, // Own read/upgrade data due
	input  wire logic        addr_cycle_i, // Incoming is address cycle
	input  wire logic [1:0]  ibuf_idx_i,   // Buffer entry for data
	input  wire logic        fwd_i,        // Forward after ACK
	input  wire logic        fwd_block_i,  // Block (else word) forward
	input  wire logic [1:0]  fwd_idx_i,    // Entry forwarded
	input  wire logic        fwd_clr_i,    // Release entry flag
	output logic             rx_valid_o,   // Accepted cycle
	output logic [11:0]      rx_cmd_o,     // Accepted command
	output logic [63:0]      rx_ad_o,      // Corrected addr/data
	output logic             resp_valid_o, // Accepted response
	output logic [4:0]       resp_o,       // Accepted response data
	output logic             cache_exc_o,  // Cache error exception
	output logic             bus_exc_o,    // Bus error exception
	output logic [3:0]       cause_o,      // Error cause register
	output logic [1:0]       set_index_o   // Index of bad entry
);
	logic [sbe_pkg::CHK_W-1:0] syn;       // Syndrome
	logic [5:0]                bitpos;    // Flipped bit
	logic                      single;    // One-bit error
	logic                      multi;     // Uncorrectable
	logic                      chk_on;    // Checking enabled
	logic                      slv_val;   // Incoming cycle
	logic                      cpar_err;  // Command parity bad
	logic                      rpar_err;  // Response parity bad
	logic                      addr_unc;  // Address uncorrectable
	logic                      data_bad;  // Read data to flag
	logic [63:0]               fixed;     // Corrected word
	logic [sbe_pkg::IBUF_N-1:0] unc_reg;  // Buffer flags

	// Master drive path, registered
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus.dev_master <= 1'b0;
			bus.dv_valid_n <= 1'b1;
			bus.dv_cmd     <= '0;
			bus.dv_cpar    <= 1'b1;
			bus.dv_ad      <= '0;
			bus.dv_chk     <= '0;
		end else begin
			bus.dev_master <= master_i;
			bus.dv_valid_n <= ~(tx_valid_i & master_i);
			bus.dv_cmd     <= tx_cmd_i;
			bus.dv_cpar    <= sbe_pkg::odd_par(tx_cmd_i); // [R1]
			bus.dv_ad      <= tx_ad_i;
			bus.dv_chk     <= sbe_pkg::ecc_gen(tx_ad_i); // [R4] [R15]
		end
	end

	// State bus with odd parity
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus.state_bus    <= '0;
			bus.state_parity <= 1'b1;
		end else begin
			bus.state_bus    <= state_i;
			bus.state_parity <= ~(^state_i); // [R11]
		end
	end

	// Decode of the incoming cycle
	always_comb begin
		slv_val  = ~bus.dev_master & ~bus.bus_valid_n;
		cpar_err = slv_val &
			(^{bus.command_bus, bus.command_parity} == 1'b0); // [R2]
		chk_on   = slv_val &
			bus.command_bus[sbe_pkg::CMD_CHK_EN_BIT] & ~cpar_err; // [R5]
		syn      = sbe_pkg::ecc_gen(bus.addr_data_bus) ^
			bus.addr_data_check_bits;
		bitpos   = '0;
		single   = 1'b0;
		for (int i = 0; i < sbe_pkg::AD_W; i++) begin
			if (syn == sbe_pkg::col(i)) begin
				bitpos = 6'(i);
				single = 1'b1;
			end
		end
		// One-hot syndrome of a check bit is also a single error
		if (syn != '0 && $countones(syn) == 1) begin
			single = 1'b1;
		end
		multi    = chk_on & (syn != '0) & ~single;
		fixed    = bus.addr_data_bus;
		if (chk_on && single && $countones(syn) != 1) begin
			fixed[bitpos] = ~fixed[bitpos]; // [R6]
		end
		addr_unc = multi & addr_cycle_i;
		data_bad = slv_val & ~cpar_err & ~addr_cycle_i & rd_pending_i &
			(multi | bus.command_bus[sbe_pkg::CMD_BAD_DATA_BIT]);
		rpar_err = ~bus.response_valid_n &
			(^{bus.response_bus, bus.response_parity} == 1'b0); // [R12]
	end

	// Accepted cycles; a bad cycle is dropped for one cycle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rx_valid_o   <= 1'b0;
			rx_cmd_o     <= '0;
			rx_ad_o      <= '0;
			resp_valid_o <= 1'b0;
			resp_o       <= '0;
		end else begin
			rx_valid_o   <= slv_val & ~cpar_err & ~addr_unc; // [R3] [R7]
			rx_cmd_o     <= bus.command_bus;
			rx_ad_o      <= fixed; // No added latency vs raw path
			resp_valid_o <= ~bus.response_valid_n & ~rpar_err; // [R13]
			resp_o       <= bus.response_bus;
		end
	end

	// Error pins, one-cycle active-low pulses
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus.correctable_error_n   <= 1'b1;
			bus.uncorrectable_error_n <= 1'b1;
		end else begin
			bus.correctable_error_n <= ~(chk_on & single & (syn != '0) &
				(addr_cycle_i | rd_pending_i)); // [R6]
			bus.uncorrectable_error_n <=
				~(cpar_err | addr_unc | rpar_err); // [R3] [R7] [R13]
		end
	end

	// Incoming buffer uncorrectable flags; set beats release
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			unc_reg <= '0;
		end else begin
			for (int e = 0; e < sbe_pkg::IBUF_N; e++) begin
				if (data_bad && ibuf_idx_i == 2'(e)) begin
					unc_reg[e] <= 1'b1; // [R8]
				end else if (fwd_clr_i && fwd_idx_i == 2'(e)) begin
					unc_reg[e] <= 1'b0;
				end
			end
		end
	end

	// Cause register bits are sticky; only reset_i clears them
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cause_o     <= sbe_pkg::CAUSE_RST;
			set_index_o <= '0;
			cache_exc_o <= 1'b0;
			bus_exc_o   <= 1'b0;
		end else begin
			cache_exc_o <= cpar_err | addr_unc | rpar_err |
				(fwd_i & fwd_block_i & unc_reg[fwd_idx_i]); // [R9]
			bus_exc_o   <= fwd_i & ~fwd_block_i &
				unc_reg[fwd_idx_i]; // [R10]
			if (cpar_err) begin
				cause_o[sbe_pkg::CAUSE_CMD_PAR_BIT] <= 1'b1; // [R3]
			end
			if (addr_unc) begin
				cause_o[sbe_pkg::CAUSE_ADDR_UNC_BIT] <= 1'b1; // [R7]
			end
			if (rpar_err) begin
				cause_o[sbe_pkg::CAUSE_RESP_PAR_BIT] <= 1'b1; // [R13] [R14]
			end
			if (fwd_i && fwd_block_i && unc_reg[fwd_idx_i]) begin
				cause_o[sbe_pkg::CAUSE_EXT_ERR_BIT] <= 1'b1; // [R9]
				set_index_o <= fwd_idx_i;
			end
		end
	end
endmodule

// [shared/sbe_pkg.sv]
package sbe_pkg;
	// Bus widths and buffer entry count
	localparam int CMD_W   = 12;
	localparam int AD_W    = 64;
	localparam int CHK_W   = 8;
	localparam int STATE_W = 3;
	localparam int RESP_W  = 5;
	localparam int IBUF_N  = 4;
	localparam int IDX_W   = 2;
	// Command bus field positions
	localparam int CMD_CHK_EN_BIT  = 0;
	localparam int CMD_BAD_DATA_BIT = 5;
	// Cause register bit positions
	localparam int CAUSE_W      = 4;
	localparam int CAUSE_CMD_PAR_BIT  = 0;
	localparam int CAUSE_ADDR_UNC_BIT = 1;
	localparam int CAUSE_RESP_PAR_BIT = 2;
	localparam int CAUSE_EXT_ERR_BIT  = 3;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h0;
	// Uncorrectable and correctable pulses last one cycle
	localparam int PULSE_CYC = 1;

	// SEC-DED check code: one odd-weight column per data bit
	function automatic logic [CHK_W-1:0] col(input int i);
		logic [CHK_W-1:0] c;
		int n;
		c = '0;
		n = 0;
		for (int v = 0; v < 256; v++) begin
			if ($countones(v[7:0]) == 3 || $countones(v[7:0]) == 5) begin
				if (n == i) begin
					c = v[7:0];
				end
				n++;
			end
		end
		return c;
	endfunction

	function automatic logic [CHK_W-1:0] ecc_gen(input logic [AD_W-1:0] d);
		logic [CHK_W-1:0] s;
		s = '0;
		for (int i = 0; i < AD_W; i++) begin
			if (d[i]) begin
				s = s ^ col(i);
			end
		end
		return s;
	endfunction

	// Odd parity bit over a bus of width w held in low bits
	function automatic logic odd_par(input logic [CMD_W-1:0] d);
		return ~(^d);
	endfunction
endpackage

// [shared/sbe_if.sv]
`timescale 1ns/1ps
interface sbe_if;
	logic        dev_master;     // Device owns the command/AD buses
	logic        bus_valid_n;    // Command/AD valid strobe
	logic [11:0] command_bus;    // Command bus
	logic        command_parity; // Odd parity over command
	logic [63:0] addr_data_bus;  // Address/data bus
	logic [7:0]  addr_data_check_bits; // Check code
	logic [2:0]  state_bus;      // Device state bus
	logic        state_parity;   // Odd parity over state
	logic        response_valid_n; // Response strobe
	logic [4:0]  response_bus;   // Response bus
	logic        response_parity; // Odd parity over response
	logic        correctable_error_n;   // Corrected pulse
	logic        uncorrectable_error_n; // Uncorrectable pulse
	// Master-side drives are muxed by dev_master
	logic        dv_valid_n, ag_valid_n;
	logic [11:0] dv_cmd, ag_cmd;
	logic        dv_cpar, ag_cpar;
	logic [63:0] dv_ad, ag_ad;
	logic [7:0]  dv_chk, ag_chk;
	assign bus_valid_n = dev_master ? dv_valid_n : ag_valid_n;
	assign command_bus = dev_master ? dv_cmd : ag_cmd;
	assign command_parity = dev_master ? dv_cpar : ag_cpar;
	assign addr_data_bus = dev_master ? dv_ad : ag_ad;
	assign addr_data_check_bits = dev_master ? dv_chk : ag_chk;
	modport device (output dev_master, dv_valid_n, dv_cmd, dv_cpar,
		dv_ad, dv_chk, state_bus, state_parity, correctable_error_n,
		uncorrectable_error_n, input bus_valid_n, command_bus,
		command_parity, addr_data_bus, addr_data_check_bits,
		response_valid_n, response_bus, response_parity);
	modport agent (output ag_valid_n, ag_cmd, ag_cpar, ag_ad, ag_chk,
		response_valid_n, response_bus, response_parity,
		input dev_master, bus_valid_n, command_bus, command_parity,
		addr_data_bus, addr_data_check_bits, state_bus, state_parity,
		correctable_error_n, uncorrectable_error_n);
endinterface

// [logic/sbe_agent.sv]
`timescale 1ns/1ps
module sbe_agent (
	input  wire logic        core_clk_i,  // System clock
	input  wire logic        reset_i,     // Sync reset, high
	sbe_if.agent             bus,         // System interface
	input  wire logic        send_i,      // Drive a cycle
	input  wire logic [11:0] cmd_i,       // Command
	input  wire logic [63:0] ad_i,        // Addr/data
	input  wire logic        rsp_send_i,  // Drive a response
	input  wire logic [4:0]  rsp_i,       // Response
	output logic             st_err_o,    // State parity wrong
	output logic             cor_seen_o,  // Correctable pulse seen
	output logic             unc_seen_o   // Uncorrectable pulse seen
);
	// Agent drives command/AD with code, response with parity
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bus.ag_valid_n       <= 1'b1;
			bus.ag_cmd           <= '0;
			bus.ag_cpar          <= 1'b1;
			bus.ag_ad            <= '0;
			bus.ag_chk           <= '0;
			bus.response_valid_n <= 1'b1;
			bus.response_bus     <= '0;
			bus.response_parity  <= 1'b1;
		end else begin
			bus.ag_valid_n       <= ~(send_i & ~bus.dev_master);
			bus.ag_cmd           <= cmd_i;
			bus.ag_cpar          <= sbe_pkg::odd_par(cmd_i); // [R2]
			bus.ag_ad            <= ad_i;
			bus.ag_chk           <= sbe_pkg::ecc_gen(ad_i); // [R5]
			bus.response_valid_n <= ~rsp_send_i;
			bus.response_bus     <= rsp_i;
			bus.response_parity  <= ~(^rsp_i); // [R12]
		end
	end

	// Watch device outputs
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_err_o   <= 1'b0;
			cor_seen_o <= 1'b0;
			unc_seen_o <= 1'b0;
		end else begin
			st_err_o   <= ^{bus.state_bus, bus.state_parity} == 1'b0;
			cor_seen_o <= ~bus.correctable_error_n;
			unc_seen_o <= ~bus.uncorrectable_error_n; // [R14]
		end
	end
endmodule

// [dv/sbe_bus_assertions.sv]
`timescale 1ns/1ps
module sbe_assertions (
	input wire logic        core_clk_i,            // Clock
	input wire logic        reset_i,               // Reset
	input wire logic        dev_master,            // Device owns bus
	input wire logic        bus_valid_n,           // Valid strobe
	input wire logic [11:0] command_bus,           // Command
	input wire logic        command_parity,        // Its parity
	input wire logic [63:0] addr_data_bus,         // Addr/data
	input wire logic [7:0]  addr_data_check_bits,  // Check code
	input wire logic [2:0]  state_bus,             // State
	input wire logic        state_parity,          // Its parity
	input wire logic        response_valid_n,      // Response strobe
	input wire logic [4:0]  response_bus,          // Response
	input wire logic        response_parity,       // Its parity
	input wire logic        correctable_error_n,   // Corrected pulse
	input wire logic        uncorrectable_error_n  // Uncorrected pulse
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// Odd-weight column code, worked out here apart from the design
	function automatic logic [7:0] gen(input logic [63:0] d);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		for (int v = 0; v < 256; v++) begin
			if ($countones(v) inside {3, 5} && n < 64) begin
				s = d[n] ? s ^ v[7:0] : s;
				n++;
			end
		end
		return s;
	endfunction
	// Clean incoming cycle: good parity and zero syndrome
	logic clean;
	assign clean = !dev_master && !bus_valid_n &&
		command_parity == ~^command_bus &&
		addr_data_check_bits == gen(addr_data_bus);
	property p_cmd_par;
		dev_master && !bus_valid_n |-> command_parity == ~^command_bus;
	endproperty
	a_cmd_par: assert property (p_cmd_par)
		else $error("bad command parity");
	property p_chk;
		dev_master && !bus_valid_n |->
			addr_data_check_bits == gen(addr_data_bus);
	endproperty
	a_chk: assert property (p_chk)
		else $error("bad check code");
	property p_state;
		!$rose(reset_i) |-> state_parity == ~^state_bus;
	endproperty
	a_state: assert property (p_state)
		else $error("bad state parity");
	property p_unc_one;
		$fell(uncorrectable_error_n) |=> uncorrectable_error_n;
	endproperty
	a_unc_one: assert property (p_unc_one)
		else $error("long unc pulse");
	property p_cor_one;
		$fell(correctable_error_n) |=> $rose(correctable_error_n);
	endproperty
	a_cor_one: assert property (p_cor_one)
		else $error("long cor pulse");
	property p_clean;
		clean |=> correctable_error_n;
	endproperty
	a_clean: assert property (p_clean)
		else $error("false correction");
	property p_nounc;
		clean && (response_valid_n || response_parity == ~^response_bus)
			|=> uncorrectable_error_n;
	endproperty
	a_nounc: assert property (p_nounc)
		else $error("false unc pulse");
	property p_rsp_err;
		!response_valid_n && response_parity != ~^response_bus
			|=> !uncorrectable_error_n;
	endproperty
	a_rsp_err: assert property (p_rsp_err)
		else $error("missed resp error");
	c_master: cover property (dev_master && !bus_valid_n);
	c_slave: cover property (clean);
	c_resp: cover property (!response_valid_n);
endmodule

// [dv/test_sysif_bus_error_checker.sv]
`timescale 1ns/1ps
module test_sysif_bus_error_checker;
	logic        core_clk_i = 0, reset_i = 1;      // Clock, reset
	logic        mst = 0, txv = 0, rdp = 0, adc = 1; // Device controls
	logic        fwd = 0, fblk = 0, fclr = 0;     // Forwarding
	logic        snd = 0, rsnd = 0;               // Agent strobes
	logic [11:0] txc = 12'h000, acmd = 12'h000;   // Commands
	logic [63:0] txa = 64'h0, aad = 64'h0;        // Addr/data
	logic [2:0]  st = 3'h0;                       // State
	logic [1:0]  idx = 2'h0, fidx = 2'h0;         // Buffer entries
	logic [4:0]  arsp = 5'h00;                    // Agent response
	logic        rxv[2], rspv[2], cexc[2], bexc[2]; // Index 1: fault link
	logic [11:0] rxc[2];                          // Taken command
	logic [63:0] rxa[2];                          // Taken addr/data
	logic [4:0]  rsp[2];                          // Taken response
	logic [3:0]  cause[2];                        // Cause registers
	logic [1:0]  set_index_field[2];                         // Bad entry index
	logic        sterr, corsn, uncsn;             // Agent observations
	logic [75:0] rows[4];                         // Command, addr/data
	logic [63:0] d = 64'h0f1e_2d3c_4b5a_6978;     // Fault test word
	int          fails = 0, checks = 0;           // Tallies
	sbe_if bus_i[2] ();                           // Main and fault links
	// Fault link has no agent: the bench drives its far side and
	// breaks rules there; both devices take the master turns
	for (genvar g = 0; g < 2; g++) begin : gen_end
		sbe_device sbe_device_inst (.core_clk_i(core_clk_i),
			.reset_i(reset_i), .bus(bus_i[g]), .master_i(mst),
			.tx_valid_i(txv), .tx_cmd_i(txc), .tx_ad_i(txa), .state_i(st),
			.rd_pending_i(rdp), .addr_cycle_i(adc), .ibuf_idx_i(idx),
			.fwd_i(fwd), .fwd_block_i(fblk), .fwd_idx_i(fidx),
			.fwd_clr_i(fclr), .rx_valid_o(rxv[g]), .rx_cmd_o(rxc[g]),
			.rx_ad_o(rxa[g]), .resp_valid_o(rspv[g]), .resp_o(rsp[g]),
			.cache_exc_o(cexc[g]), .bus_exc_o(bexc[g]),
			.cause_o(cause[g]), .set_index_o(set_index_field[g]));
	end
	sbe_agent sbe_agent_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.bus(bus_i[0]), .send_i(snd), .cmd_i(acmd), .ad_i(aad),
		.rsp_send_i(rsnd), .rsp_i(arsp), .st_err_o(sterr),
		.cor_seen_o(corsn), .unc_seen_o(uncsn));
	sbe_assertions sbe_assertions_inst (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .dev_master(bus_i[1].dev_master),
		.bus_valid_n(bus_i[1].bus_valid_n),
		.command_bus(bus_i[1].command_bus),
		.command_parity(bus_i[1].command_parity),
		.addr_data_bus(bus_i[1].addr_data_bus),
		.addr_data_check_bits(bus_i[1].addr_data_check_bits),
		.state_bus(bus_i[1].state_bus),
		.state_parity(bus_i[1].state_parity),
		.response_valid_n(bus_i[1].response_valid_n),
		.response_bus(bus_i[1].response_bus),
		.response_parity(bus_i[1].response_parity),
		.correctable_error_n(bus_i[1].correctable_error_n),
		.uncorrectable_error_n(bus_i[1].uncorrectable_error_n));
	// 8 ns period
	initial begin
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input string n, input logic [75:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One cycle on the fault link; released data shows its inverse
	task automatic hit(input logic cv, rv, input logic [11:0] c,
		input logic p, input logic [63:0] a, input logic [7:0] k);
		@(posedge core_clk_i);
		bus_i[1].ag_valid_n <= ~cv;
		bus_i[1].response_valid_n <= ~rv;
		bus_i[1].ag_cmd <= c;
		bus_i[1].response_bus <= c[4:0];
		bus_i[1].ag_cpar <= p;
		bus_i[1].response_parity <= p;
		bus_i[1].ag_ad <= a;
		bus_i[1].ag_chk <= k;
		@(posedge core_clk_i);
		bus_i[1].ag_valid_n <= 1'b1;
		bus_i[1].response_valid_n <= 1'b1;
		bus_i[1].ag_ad <= ~a;
		#1;
	endtask
	// Forward an entry, look one edge later
	task automatic fw(input logic b);
		@(posedge core_clk_i);
		fwd <= 1'b1;
		fblk <= b;
		fidx <= 2'h2;
		@(posedge core_clk_i);
		fwd <= 1'b0;
		#1;
	endtask
	initial begin
		bus_i[1].ag_valid_n = 1'b1;
		bus_i[1].response_valid_n = 1'b1;
		rows = '{{12'h001, 64'h0}, {12'h001, 64'hffff_ffff_ffff_ffff},
			{12'h7f1, 64'h8000_0000_0000_0001}, {12'h000, d}};
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'b0;
		#1;
		chk("cause", 4'h0, cause[1]);
		// Ordinary traffic in both directions on the main link
		foreach (rows[i]) begin
			@(posedge core_clk_i);
			{acmd, aad} <= rows[i];
			arsp <= rows[i][4:0];
			st <= 3'(i);
			snd <= 1'b1;
			rsnd <= 1'b1;
			@(posedge core_clk_i);
			snd <= 1'b0;
			rsnd <= 1'b0;
			for (int n = 0; rxv[0] !== 1'b1; n++) begin
				if (n == 8) begin
					fails++;
					summarize();
				end
				@(posedge core_clk_i);
				#1;
			end
			chk("rx", rows[i], {rxc[0], rxa[0]});
			chk("resp", {1'b1, rows[i][4:0]}, {rspv[0], rsp[0]});
			chk("agent", 3'h0, {sterr, corsn, uncsn});
			@(posedge core_clk_i);
			mst <= 1'b1;
			txv <= 1'b1;
			{txc, txa} <= rows[i];
			@(posedge core_clk_i);
			txv <= 1'b0;
			mst <= 1'b0;
			$display("row %0d done", i);
		end
		// Odd parity: a command with one set bit carries 0, none carries 1
		hit(1, 0, 12'h001, 0, d ^ 64'h80, sbe_assertions_inst.gen(d));
		chk("fix", {2'h2, d},
			{rxv[1], bus_i[1].correctable_error_n, rxa[1]});
		hit(1, 0, 12'h000, 1, d ^ 64'h1, 8'h00);
		chk("raw", {2'h3, d ^ 64'h1},
			{rxv[1], bus_i[1].correctable_error_n, rxa[1]});
		hit(1, 0, 12'h001, 1, d, sbe_assertions_inst.gen(d));
		chk("cmd err", 8'h11, {rxv[1], uncsn, bus_i[1].uncorrectable_error_n,
			cexc[1], cause[1]});
		hit(1, 0, 12'h001, 0, d ^ 64'h3, sbe_assertions_inst.gen(d));
		chk("dbl err", 8'h13, {rxv[1], 1'b0, bus_i[1].uncorrectable_error_n,
			cexc[1], cause[1]});
		hit(0, 1, 12'h013, 0, d, 8'h00);
		chk("rsp ok", 6'h33, {rspv[1], rsp[1]});
		hit(0, 1, 12'h013, 1, d, 8'h00);
		chk("rsp err", 6'h07, {rspv[1], bus_i[1].uncorrectable_error_n,
			cause[1]});
		$display("fault cycles done");
		@(posedge core_clk_i);
		adc <= 1'b0;
		rdp <= 1'b1;
		idx <= 2'h2;
		// Bits 0 and 5 set, so good parity is 1
		hit(1, 0, 12'h021, 1, d, sbe_assertions_inst.gen(d));
		fw(1'b0);
		chk("bus exc", 2'h2, {bexc[1], cexc[1]});
		fw(1'b1);
		chk("blk exc", 7'h6f, {cexc[1], set_index_field[1], cause[1]});
		@(posedge core_clk_i);
		#1;
		chk("one exc", 1'b0, cexc[1]);
		// A released entry must not raise the exception again
		@(posedge core_clk_i);
		fclr <= 1'b1;
		@(posedge core_clk_i);
		fclr <= 1'b0;
		fw(1'b1);
		chk("cleared", 1'b0, cexc[1]);
		$display("buffer flag done");
		summarize();
	end
endmodule
